/* verilog/smo_pkg.sv */
package smo_pkg;
    // ******************************************
    // Register byte offsets
    // ******************************************
    localparam logic [11:0] SMO_OFS_THREE_V = 12'h034;
    localparam logic [11:0] SMO_OFS_FIVE_V = 12'h038;
    localparam logic [11:0] SMO_OFS_CORE_TRIM = 12'h03C;
    localparam logic [11:0] SMO_OFS_IO_REG = 12'h040;
    localparam logic [11:0] SMO_OFS_SYS_RC = 12'h044;
    localparam logic [11:0] SMO_OFS_DUAL_RC = 12'h048;
    localparam logic [11:0] SMO_OFS_SLOW_OSC = 12'h04C;
    localparam logic [11:0] SMO_OFS_UNLOCK = 12'h050;
    localparam logic [11:0] SMO_OFS_RESET_CAUSE = 12'h054;
    // ******************************************
    // Unlock word: key in 31:24, target offset in 11:0
    // ******************************************
    localparam logic [7:0] SMO_UNLOCK_KEY = 8'hAA;
    localparam int SMO_KEY_LSB = 24;
    // ******************************************
    // Field positions
    // ******************************************
    localparam int SMO_FREEZE_BIT = 31;
    localparam int SMO_FUSE_BIT = 16;
    localparam int SMO_SUP_CTRL_LSB = 8;
    localparam int SMO_HYSTERESIS_ON_BIT = 6;
    localparam int SMO_IO_SW_LSB = 1;
    localparam int SMO_RATE_BIT = 25;
    localparam int SMO_RC_ON_BIT = 24;
    localparam int SMO_START_LSB = 16;
    localparam int SMO_MODE_LSB = 8;
    // ******************************************
    // Writable masks (reserved bits read zero)
    // ******************************************
    localparam logic [31:0] SMO_MASK_THREE_V = 32'h8001037F;
    localparam logic [31:0] SMO_MASK_FIVE_V = 32'h8000017F;
    localparam logic [31:0] SMO_MASK_CORE_TRIM = 32'h80010007;
    localparam logic [31:0] SMO_MASK_IO_REG = 32'h80000006;
    localparam logic [31:0] SMO_MASK_SYS_RC = 32'h000103FF;
    localparam logic [31:0] SMO_MASK_DUAL_RC = 32'h030100FF;
    localparam logic [31:0] SMO_MASK_SLOW_OSC = 32'h00070301;
    localparam logic [31:0] SMO_RESET_VALUE = 32'h00000000;
    // ******************************************
    // Codes
    // ******************************************
    localparam logic [1:0] SMO_SUP_OFF = 2'h0;
    localparam logic [1:0] SMO_SUP_RESET = 2'h1;
    localparam logic [1:0] SMO_SUP_IRQ = 2'h2;
    localparam logic [1:0] SMO_IO_ON = 2'h0;
    localparam logic [1:0] SMO_IO_OFF = 2'h3;
    localparam logic [1:0] SMO_SLOW_RESERVED = 2'h3;
    localparam int SMO_NUM_REGS = 7;

    typedef enum logic [1:0] {
        SMO_RST_POWER_ON,
        SMO_RST_THREE_V,
        SMO_RST_OTHER
    } smo_rst_kind_t;

    typedef struct packed {
        logic [11:0] addr;
        logic write;
        logic [31:0] wdata;
        logic valid;
    } smo_req_t;

    typedef struct packed {
        logic [1:0] three_v_mode;
        logic three_v_hysteresis_on;
        logic [5:0] three_v_level;
        logic five_v_on;
        logic five_v_hysteresis_on;
        logic [5:0] five_v_level;
        logic [2:0] core_trim;
        logic io_reg_on;
        logic [9:0] sys_rc_trim;
        logic dual_rc_on;
        logic dual_rc_1mhz;
        logic [7:0] dual_rc_trim;
        logic slow_osc_on;
        logic [1:0] slow_osc_mode;
        logic [2:0] slow_osc_start;
    } smo_ctrl_t;

    typedef struct packed {
        logic [2:0] core_trim;
        logic [9:0] sys_rc_trim;
        logic [7:0] dual_rc_trim;
        logic [9:0] three_v_ctrl;
    } smo_fuse_t;

    // Startup wait in system RC cycles for each code
    function automatic logic [19:0] smo_startup_cycles(input logic [2:0] code);
        unique case (code)
            3'h0: return 20'h00000;
            3'h1: return 20'h00080;
            3'h2: return 20'h02000;
            3'h3: return 20'h04000;
            3'h4: return 20'h10000;
            3'h5: return 20'h20000;
            3'h6: return 20'h40000;
            3'h7: return 20'h80000;
        endcase
    endfunction
endpackage

/* verilog/smo_apb_slave.sv */
`timescale 1ns/100ps
// Zero-wait APB front end; presents one-cycle request pulses at the access phase.
module smo_apb_slave
    import smo_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output smo_req_t req
);
    always_comb begin
        req.addr = paddr;
        req.write = pwrite;
        req.wdata = pwdata;
        req.valid = psel & penable;
    end
endmodule // smo_apb_slave

/* verilog/smo_fuse_loader.sv */
`timescale 1ns/100ps
// ******************************************
// Decides on which reset each fuse-loaded field reloads
// ******************************************
module smo_fuse_loader
    import smo_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic fuse_valid,
    input smo_rst_kind_t rst_kind,
    input wire logic three_v_done,
    input wire logic trim_done,
    output logic load_three_v,
    output logic load_trims
);
    typedef struct packed {
        logic pending;
    } smo_fl_state_t;
    smo_fl_state_t state_reg, state_next;

    always_comb begin
        state_next = state_reg;
        load_three_v = 1'b0;
        load_trims = 1'b0;
        if (state_reg.pending && fuse_valid) begin
            state_next.pending = 1'b0;
            // Skip only when already loaded and this was a supervisor reset
            load_three_v = !(three_v_done && rst_kind == SMO_RST_THREE_V);
            // Loaded trims reload on power-on reset only
            load_trims = !trim_done || rst_kind == SMO_RST_POWER_ON;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '{pending: 1'b1};
        end else begin
            state_reg <= state_next;
        end
    end
endmodule // smo_fuse_loader

/* verilog/smo_config_regs.sv */
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
// Overview of operation
// - Fuse load sets done flag; skipped after supervisor reset once set (presetn clears the flag here, so the load always runs).
// - 3.3V mode: 0 off, 1 reset, 2 interrupt only, 3 reserved.
// - 3.3V threshold field and hysteresis bit drive the supervisor.
// - Locked registers accept a write only after an unlock write.
// - Freeze bit 31 set makes the register read-only.
// - 5V supervisor enable at bit 8 of offset 0x38.
// - 5V threshold field and hysteresis bit drive the supervisor.
// - Fuse load sets done flag in core, system RC, dual RC trims.
// - Trim done flag 0 reloads after any reset, 1 only power-on (presetn clears the flag here, so every reset reloads).
// - Core trim drives the 1.8V regulator reference trim.
// - IO regulator on at code 0, off at 3; 1 and 2 reserved.
// - System RC trim is ten bits split 9:8 and 7:0.
// - Dual RC rate bit: 0 gives 8 MHz, 1 gives 1 MHz.
// - Dual RC enable bit and eight-bit trim in bits 7:0.
// - Slow oscillator register cleared only by power-on reset (presetn still zeroes its ctrl fields and slow_osc_wait until the next clock).
// - Slow oscillator enable bit stops or runs it.
// - Slow oscillator mode: external, crystal, crystal current, reserved.
// - Startup code selects 0 to 524288 system RC cycles.
module smo_config_regs
    import smo_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic por_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input smo_rst_kind_t rst_kind,
    input wire logic fuse_valid,
    input smo_fuse_t fuse_data,
    output smo_ctrl_t ctrl,
    output logic three_v_reset_en,
    output logic three_v_irq_en,
    output logic [19:0] slow_osc_wait
);
    // ******************************************
    // State
    // ******************************************
    typedef struct packed {
        logic [31:0] three_v;
        logic [31:0] five_v;
        logic [31:0] core_trim;
        logic [31:0] io_reg;
        logic [31:0] sys_rc;
        logic [31:0] dual_rc;
        logic unlocked;
        logic [11:0] unlock_ofs;
        logic [31:0] rdata;
        logic slverr;
        smo_ctrl_t ctrl;
        logic rst_en;
        logic irq_en;
        logic [19:0] wait_cycles;
    } smo_state_t;
    smo_state_t state_reg, state_next;
    // Kept apart because it lives on the power-on reset only
    logic [31:0] slow_osc_reg, slow_osc_next;

    smo_req_t req;
    logic load_three_v, load_trims;

    smo_apb_slave u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .req(req)
    );

    smo_fuse_loader u_fuse (
        .pclk(pclk),
        .presetn(presetn),
        .fuse_valid(fuse_valid),
        .rst_kind(rst_kind),
        .three_v_done(state_reg.three_v[SMO_FUSE_BIT]),
        .trim_done(state_reg.core_trim[SMO_FUSE_BIT]),
        .load_three_v(load_three_v),
        .load_trims(load_trims)
    );

    // Locked writes need the unlock key aimed at this offset; freeze bit blocks all.
    function automatic logic smo_may_write(input logic [31:0] cur, input logic locked,
                                           input logic unl, input logic [11:0] unl_ofs,
                                           input logic [11:0] ofs);
        logic ok;
        ok = !cur[SMO_FREEZE_BIT];
        if (locked) begin
            ok = ok && unl && unl_ofs == ofs;
        end
        return ok;
    endfunction

    // Merge written data under a writable mask; done flag is hardware-owned.
    function automatic logic [31:0] smo_merge(input logic [31:0] wdata,
                                              input logic [31:0] cur,
                                              input logic [31:0] mask);
        logic [31:0] fuse_bit;
        fuse_bit = 32'h00000001 << SMO_FUSE_BIT;
        return (wdata & mask & ~fuse_bit) | (cur & fuse_bit);
    endfunction

    // ******************************************
    // Next state
    // ******************************************
    always_comb begin
        logic wr, rd;
        wr = 1'b0;
        rd = 1'b0;
        state_next = state_reg;
        slow_osc_next = slow_osc_reg;
        state_next.slverr = 1'b0;
        // Answer is registered in the setup phase so it stands at the access edge
        wr = req.valid && req.write;
        rd = psel && !penable;
        if (wr) begin
            unique case (req.addr)
                SMO_OFS_THREE_V: if (smo_may_write(state_reg.three_v, 1'b1, state_reg.unlocked,
                        state_reg.unlock_ofs, SMO_OFS_THREE_V)) begin
                    state_next.three_v = smo_merge(req.wdata, state_reg.three_v,
                                                   SMO_MASK_THREE_V);
                end
                SMO_OFS_FIVE_V: if (smo_may_write(state_reg.five_v, 1'b1, state_reg.unlocked,
                        state_reg.unlock_ofs, SMO_OFS_FIVE_V)) begin
                    state_next.five_v = smo_merge(req.wdata, state_reg.five_v, SMO_MASK_FIVE_V);
                end
                SMO_OFS_CORE_TRIM: if (smo_may_write(state_reg.core_trim, 1'b0, 1'b0, 12'h000,
                        SMO_OFS_CORE_TRIM)) begin
                    state_next.core_trim = smo_merge(req.wdata, state_reg.core_trim,
                                                     SMO_MASK_CORE_TRIM);
                end
                SMO_OFS_IO_REG: if (smo_may_write(state_reg.io_reg, 1'b0, 1'b0, 12'h000,
                        SMO_OFS_IO_REG)) begin
                    state_next.io_reg = smo_merge(req.wdata, state_reg.io_reg, SMO_MASK_IO_REG);
                end
                SMO_OFS_SYS_RC: begin
                    state_next.sys_rc = smo_merge(req.wdata, state_reg.sys_rc, SMO_MASK_SYS_RC);
                end
                SMO_OFS_DUAL_RC: begin
                    state_next.dual_rc = smo_merge(req.wdata, state_reg.dual_rc,
                                                   SMO_MASK_DUAL_RC);
                end
                SMO_OFS_SLOW_OSC: begin
                    slow_osc_next = req.wdata & SMO_MASK_SLOW_OSC;
                end
                SMO_OFS_UNLOCK: begin
                    state_next.unlocked = req.wdata[31:SMO_KEY_LSB] == SMO_UNLOCK_KEY;
                    state_next.unlock_ofs = req.wdata[11:0];
                end
                // Unmapped writes are already flagged in their setup phase
                default: begin
                end
            endcase
            // Any write other than the unlock itself consumes the unlock
            if (req.addr != SMO_OFS_UNLOCK) begin
                state_next.unlocked = 1'b0;
            end
        end
        if (rd) begin
            unique case (req.addr)
                SMO_OFS_THREE_V: state_next.rdata = state_reg.three_v;
                SMO_OFS_FIVE_V: state_next.rdata = state_reg.five_v;
                SMO_OFS_CORE_TRIM: state_next.rdata = state_reg.core_trim;
                SMO_OFS_IO_REG: state_next.rdata = state_reg.io_reg;
                SMO_OFS_SYS_RC: state_next.rdata = state_reg.sys_rc;
                SMO_OFS_DUAL_RC: state_next.rdata = state_reg.dual_rc;
                SMO_OFS_SLOW_OSC: state_next.rdata = slow_osc_reg;
                SMO_OFS_UNLOCK: state_next.rdata = {31'h00000000, state_reg.unlocked};
                SMO_OFS_RESET_CAUSE: state_next.rdata = {30'h00000000, rst_kind};
                default: begin
                    state_next.rdata = SMO_RESET_VALUE;
                    state_next.slverr = 1'b1;
                end
            endcase
        end
        // ******************************************
        // Fuse loads (hardware set wins over software)
        // ******************************************
        if (load_three_v) begin
            state_next.three_v[9:0] = fuse_data.three_v_ctrl & SMO_MASK_THREE_V[9:0];
            state_next.three_v[SMO_FUSE_BIT] = 1'b1;
        end
        if (load_trims) begin
            state_next.core_trim[2:0] = fuse_data.core_trim;
            state_next.sys_rc[9:0] = fuse_data.sys_rc_trim;
            state_next.dual_rc[7:0] = fuse_data.dual_rc_trim;
            state_next.core_trim[SMO_FUSE_BIT] = 1'b1;
            state_next.sys_rc[SMO_FUSE_BIT] = 1'b1;
            state_next.dual_rc[SMO_FUSE_BIT] = 1'b1;
        end
        // ******************************************
        // Decoded controls toward the analog blocks
        // ******************************************
        state_next.ctrl.three_v_mode = state_next.three_v[9:8];
        state_next.ctrl.three_v_hysteresis_on = state_next.three_v[SMO_HYSTERESIS_ON_BIT];
        state_next.ctrl.three_v_level = state_next.three_v[5:0];
        state_next.rst_en = state_next.three_v[9:8] == SMO_SUP_RESET;
        state_next.irq_en = state_next.three_v[9:8] == SMO_SUP_IRQ;
        state_next.ctrl.five_v_on = state_next.five_v[SMO_SUP_CTRL_LSB];
        state_next.ctrl.five_v_hysteresis_on = state_next.five_v[SMO_HYSTERESIS_ON_BIT];
        state_next.ctrl.five_v_level = state_next.five_v[5:0];
        state_next.ctrl.core_trim = state_next.core_trim[2:0];
        // Reserved codes keep the regulator on, the safe choice
        state_next.ctrl.io_reg_on = state_next.io_reg[2:1] != SMO_IO_OFF;
        state_next.ctrl.sys_rc_trim = state_next.sys_rc[9:0];
        state_next.ctrl.dual_rc_on = state_next.dual_rc[SMO_RC_ON_BIT];
        state_next.ctrl.dual_rc_1mhz = state_next.dual_rc[SMO_RATE_BIT];
        state_next.ctrl.dual_rc_trim = state_next.dual_rc[7:0];
        state_next.ctrl.slow_osc_on = slow_osc_next[0];
        state_next.ctrl.slow_osc_mode = slow_osc_next[9:8];
        state_next.ctrl.slow_osc_start = slow_osc_next[18:16];
        state_next.wait_cycles = smo_startup_cycles(slow_osc_next[18:16]);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
            state_reg.ctrl.io_reg_on <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // Power-on reset only; system resets leave it alone
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            slow_osc_reg <= SMO_RESET_VALUE;
        end else begin
            slow_osc_reg <= slow_osc_next;
        end
    end

    always_comb begin
        prdata = state_reg.rdata;
        pslverr = state_reg.slverr;
        pready = 1'b1;
        ctrl = state_reg.ctrl;
        three_v_reset_en = state_reg.rst_en;
        three_v_irq_en = state_reg.irq_en;
        slow_osc_wait = state_reg.wait_cycles;
    end

    // ******************************************
    // Checks
    // ******************************************
    a_freeze_holds: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg.core_trim[SMO_FREEZE_BIT] |=> $stable(state_reg.core_trim))
        else $error("frozen register changed");
    a_lock_blocks_write: assert property (@(posedge pclk) disable iff (!presetn)
        req.valid && req.write && req.addr == SMO_OFS_FIVE_V && !state_reg.unlocked
        |=> $stable(state_reg.five_v))
        else $error("locked write took effect");
    a_fuse_sets_done: assert property (@(posedge pclk) disable iff (!presetn)
        load_trims |=> state_reg.sys_rc[SMO_FUSE_BIT] && state_reg.dual_rc[SMO_FUSE_BIT])
        else $error("trim done flag not set");
    a_three_v_done: assert property (@(posedge pclk) disable iff (!presetn)
        load_three_v |=> state_reg.three_v[SMO_FUSE_BIT])
        else $error("supervisor done flag not set");
    a_reset_mode: assert property (@(posedge pclk) disable iff (!presetn)
        three_v_reset_en == (state_reg.three_v[9:8] == SMO_SUP_RESET))
        else $error("reset enable mismatch");
    a_io_reg_off: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl.io_reg_on == (state_reg.io_reg[2:1] != SMO_IO_OFF))
        else $error("regulator switch mismatch");
    a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (slow_osc_reg & ~SMO_MASK_SLOW_OSC) == 32'h00000000)
        else $error("reserved bit set");
    a_rate_select: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl.dual_rc_1mhz == state_reg.dual_rc[SMO_RATE_BIT])
        else $error("rate select mismatch");
endmodule // smo_config_regs

/* tb/smo_config_regs_tb.sv */
`timescale 1ns/100ps
module testbench;
    import smo_pkg::*;
    logic pclk;
    logic presetn;
    logic por_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic fuse_valid;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rv_err;
    smo_rst_kind_t rst_kind;
    smo_fuse_t fuse_data;
    smo_ctrl_t ctrl;
    logic three_v_reset_en;
    logic three_v_irq_en;
    logic [19:0] slow_osc_wait;
    logic [31:0] rd;
    logic [31:0] r;
    logic [31:0] mdl [0:6];
    logic unl;
    logic [11:0] unl_ofs;
    int fail_count = 0;
    int checks_done = 0;
    int cyc = 0;
    logic [31:0] msk [0:6] = '{SMO_MASK_THREE_V, SMO_MASK_FIVE_V, SMO_MASK_CORE_TRIM,
        SMO_MASK_IO_REG, SMO_MASK_SYS_RC, SMO_MASK_DUAL_RC, SMO_MASK_SLOW_OSC};
    logic [19:0] waits [0:7] = '{20'h00000, 20'h00080, 20'h02000, 20'h04000,
        20'h10000, 20'h20000, 20'h40000, 20'h80000};

    smo_config_regs dut (.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rst_kind(rst_kind), .fuse_valid(fuse_valid),
        .fuse_data(fuse_data), .ctrl(ctrl), .three_v_reset_en(three_v_reset_en),
        .three_v_irq_en(three_v_irq_en), .slow_osc_wait(slow_osc_wait));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // ****************************************
    // Checking and bus tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Read data and error are taken at the edge where pready is seen high
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        rv_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Model: done flag is hardware only; an unlock covers the very next write only
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int i;
        logic [31:0] wm;
        bus(1'b1, a, d);
        i = (int'(a) - 'h34) / 4;
        if (a == SMO_OFS_UNLOCK) begin
            unl = (d[31:24] == SMO_UNLOCK_KEY);
            unl_ofs = d[11:0];
        end else begin
            // Bit 16 is the done flag except in the slow oscillator startup field
            wm = (i < 6) ? msk[i] & 32'hFFFEFFFF : msk[i];
            if (!(i < 2 && !(unl && unl_ofs == a)) && !(i < 4 && mdl[i][31]))
                mdl[i] = (mdl[i] & ~wm) | (d & wm);
            unl = 1'b0;
        end
    endtask

    task automatic rdc(input int i);
        bus(1'b0, 12'(12'h034 + 4 * i), 32'h00000000);
        chk(rd, mdl[i]);
        chk(32'(rv_err), 32'h00000000);
    endtask

    task automatic rst(input logic por);
        fuse_data <= {3'($urandom), 10'($urandom), 8'($urandom), 10'h000};
        presetn <= 1'b0;
        por_n <= !por;
        rst_kind <= por ? SMO_RST_POWER_ON : SMO_RST_OTHER;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        por_n <= 1'b1;
        @(posedge pclk);
        if (por) begin
            unl = 1'b0;
            mdl = '{32'h00010000, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
            mdl[2] = 32'h00010000 | 32'(fuse_data.core_trim);
            mdl[4] = 32'h00010000 | 32'(fuse_data.sys_rc_trim);
            mdl[5] = 32'h00010000 | 32'(fuse_data.dual_rc_trim);
        end
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            print_verdict;
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(16935));
        {presetn, por_n, psel, penable, pwrite} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        fuse_valid = 1'b1;
        rst_kind = SMO_RST_POWER_ON;
        fuse_data = '0;
        rst(1'b1);
        for (int i = 0; i < 7; i++) rdc(i);
        bus(1'b0, 12'h0F0, 32'h00000000);
        chk(rd, 32'h00000000);
        chk(32'(rv_err), 32'h00000001);
        wr(SMO_OFS_FIVE_V, 32'h0000017F);
        rdc(1);
        wr(SMO_OFS_UNLOCK, 32'hAA000038);
        wr(SMO_OFS_CORE_TRIM, 32'h00000002);
        wr(SMO_OFS_FIVE_V, 32'h0000017F);
        rdc(1);
        wr(SMO_OFS_UNLOCK, 32'hAA000038);
        wr(SMO_OFS_FIVE_V, $urandom & 32'h7FFFFFFF);
        rdc(1);
        chk(32'(ctrl.five_v_on), 32'(mdl[1][8]));
        chk(32'({ctrl.five_v_hysteresis_on, ctrl.five_v_level}), 32'(mdl[1][6:0]));
        for (int m = 0; m < 4; m++) begin
            r = $urandom & 32'h7FFFFCFF;
            // Switch off first, change the threshold, then pick the mode
            wr(SMO_OFS_UNLOCK, 32'hAA000034);
            wr(SMO_OFS_THREE_V, mdl[0] & 32'hFFFFFCFF);
            wr(SMO_OFS_UNLOCK, 32'hAA000034);
            wr(SMO_OFS_THREE_V, r);
            wr(SMO_OFS_UNLOCK, 32'hAA000034);
            wr(SMO_OFS_THREE_V, r | (m << 8));
            rdc(0);
            chk(32'({three_v_reset_en, three_v_irq_en}), 32'({m == 1, m == 2}));
            chk(32'({ctrl.three_v_hysteresis_on, ctrl.three_v_level}), 32'(mdl[0][6:0]));
        end
        for (int k = 0; k < 8; k++) begin
            r = $urandom & 32'h7FFFFFF9;
            wr(SMO_OFS_CORE_TRIM, r);
            wr(SMO_OFS_IO_REG, r | ((k & 3) << 1));
            wr(SMO_OFS_SYS_RC, $urandom);
            wr(SMO_OFS_DUAL_RC, $urandom);
            wr(SMO_OFS_SLOW_OSC, ($urandom & 32'hFFF8FFFF) | (k << 16));
            for (int j = 2; j < 7; j++) rdc(j);
            chk(32'(ctrl.core_trim), 32'(mdl[2][2:0]));
            chk(32'(ctrl.io_reg_on), 32'((k & 3) != 3));
            chk(32'(ctrl.sys_rc_trim), 32'(mdl[4][9:0]));
            chk(32'({ctrl.dual_rc_1mhz, ctrl.dual_rc_on}), 32'(mdl[5][25:24]));
            chk(32'(ctrl.dual_rc_trim), 32'(mdl[5][7:0]));
            chk(32'(ctrl.slow_osc_on), 32'(mdl[6][0]));
            chk(32'(ctrl.slow_osc_mode), 32'(mdl[6][9:8]));
            chk(32'(slow_osc_wait), 32'(waits[k]));
        end
        wr(SMO_OFS_CORE_TRIM, 32'h80000005);
        wr(SMO_OFS_CORE_TRIM, 32'h00000002);
        rdc(2);
        r = mdl[6];
        rst(1'b0);
        bus(1'b0, SMO_OFS_SLOW_OSC, 32'h00000000);
        chk(rd, r);
        rst(1'b1);
        for (int i = 2; i < 7; i++) rdc(i);
        print_verdict;
    end
endmodule // testbench
